// ===== inc/pfs_pkg.sv
package pfs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLOCK_MHZ        = 250;
	localparam int unsigned OC_TIMEOUT_MS    = 50;
	localparam int unsigned DISC_TIMEOUT_MS  = 300;
	localparam int unsigned SETTLE_MS        = 4;
	localparam int unsigned OC_CYCLES        =
		OC_TIMEOUT_MS * 1000 * CLOCK_MHZ;
	localparam int unsigned DISC_CYCLES      =
		DISC_TIMEOUT_MS * 1000 * CLOCK_MHZ;
	localparam int unsigned SETTLE_CYCLES    =
		SETTLE_MS * 1000 * CLOCK_MHZ;
	localparam int unsigned PORTS            = 4;
	localparam int unsigned SAMPLES_PER_LOOP = 31;

	// ----------------------------------------------------------------
	// fault codes and result layout
	// ----------------------------------------------------------------
	localparam logic [2:0] FAULT_NONE       = 3'h0;
	localparam logic [2:0] FAULT_OVERCURR   = 3'h2;
	localparam logic [2:0] FAULT_DISCONNECT = 3'h3;
	localparam int unsigned RESULT_W        = 16;
	localparam int unsigned DONE_BIT        = 15;
	localparam logic [15:0] RESULT_RESET    = 16'h0000;

	// ----------------------------------------------------------------
	// function codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		FN_DISABLE     = 4'h0,
		FN_DISCOVER1   = 4'h1,
		FN_DISCOVER2   = 4'h2,
		FN_VSAMPLE     = 4'h3,
		FN_LEGACY      = 4'h4,
		FN_CLASSIFY    = 4'h5,
		FN_RAMP_UP     = 4'h6,
		FN_CONT_SAMPLE = 4'h7,
		FN_RAMP_DOWN   = 4'h8,
		FN_LOW_AC      = 4'h9,
		FN_HIGH_AC     = 4'hA,
		FN_CURRENT_SAMPLE_FUNCTION     = 4'hB,
		FN_TEMPERATURE_SAMPLE_FUNCTION     = 4'hC
	} pfs_func_t;

	// analog channel that a conversion reads
	typedef enum logic [1:0] {
		CH_CURRENT = 2'h0,
		CH_VOLTAGE = 2'h1,
		CH_TEMP    = 2'h2
	} pfs_chan_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_SETTLE  = 3'h1,
		ST_CONVERT = 3'h2,
		ST_RAMP    = 3'h3,
		ST_DONE    = 3'h4
	} pfs_state_t;

endpackage

// ===== src/pfs_fault_timer.sv
`timescale 1ns/1ps

// one fault timer: counts while the condition holds, restarts when it ends
module pfs_fault_timer #(
	parameter int unsigned LIMIT = 1000
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic arm,
	input  wire logic cond,
	output logic      expired
);

	localparam int unsigned CW = $clog2(LIMIT + 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          expired;
	} pfs_ft_state_t;

	pfs_ft_state_t cur;
	pfs_ft_state_t next_cur;

	if (LIMIT < 1)
	begin : g_bad_limit
		$error("fault timer limit must be at least one");
	end

	always_comb
	begin
		next_cur = cur;
		next_cur.expired = 1'b0;
		if (!arm || !cond)
			next_cur.count = '0;
		else if (cur.count == CW'(LIMIT - 1))
		begin
			next_cur.count = '0;
			next_cur.expired = 1'b1;
		end
		else
			next_cur.count = cur.count + CW'(1);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign expired = cur.expired;

endmodule // pfs_fault_timer

// ===== src/pfs_port_sequencer.sv
`timescale 1ns/1ps

// Functional notes
// R1: overcurrent or current-limit trip starts its current fault timer.
// R2: current timer timeout turns port off, latches overcurrent code.
// R3: overcurrent clearing early resets the current timer, no shutdown.
// R4: powered port below disconnect threshold starts the disconnect timer; the code arms it only during continuous sample.
// R5: disconnect timeout turns port off, latches load-disconnect code.
// R6: undercurrent ending early resets the disconnect timer, port stays on.
// R7: host drives thirteen functions, waits for done before reading results.
// R8: a function's condition and result are held until the next call.
// R9: disable switches the port off and resets all functions.
// R10: first discovery applies low probe voltage, measures and stores current.
// R11: second discovery applies high probe voltage, stores measured current.
// R12: voltage sample stores port voltage in the voltage result.
// R13: legacy enables current source, stores port voltage.
// R14: classify applies class voltage, measures and stores current.
// R15: ramp-up turns switch on with controlled current until met or limit.
// R16: continuous sample loops 31 current then one voltage conversion.
// R17: ramp-down turns switch off until current is zero, then done.
// R18: AC functions turn on one transistor, store port voltage.
// R19: current sample stores current; temperature sample stores temperature.
// R20: each result carries a done flag in its top bit.
// R21: host must not call again while a conversion is in progress.
// R22: conversion time is variable; completion comes from the converter.
// R23: timers and function state are separate for each port.
module pfs_port_sequencer #(
	parameter int unsigned OC_LIMIT     = pfs_pkg::OC_CYCLES,
	parameter int unsigned DISC_LIMIT   = pfs_pkg::DISC_CYCLES,
	parameter int unsigned SETTLE_LIMIT = pfs_pkg::SETTLE_CYCLES
) (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic [3:0]          overcurrent_comparator,
	input  wire logic [3:0]          current_limit_comparator,
	input  wire logic [3:0]          undercurrent,
	input  wire logic [3:0]          ramp_complete,
	input  wire logic                host_managed_mode,
	input  wire logic                call_valid,
	input  wire logic [1:0]          call_port,
	input  wire logic [3:0]          call_func,
	input  wire logic [3:0]          conv_done,
	input  wire logic [14:0]         conv_data,
	output logic      [3:0]          port_power,
	output logic      [3:0]          probe_low,
	output logic      [3:0]          probe_high,
	output logic      [3:0]          class_drive,
	output logic      [3:0]          legacy_source,
	output logic      [3:0]          ramp_up,
	output logic      [3:0]          ramp_down,
	output logic      [3:0]          low_fet_on,
	output logic      [3:0]          high_fet_on,
	output logic      [3:0]          conv_start,
	output logic      [7:0]          conv_chan,
	output logic      [3:0]          func_done,
	output logic      [11:0]         fault_code,
	output logic      [63:0]         current_result,
	output logic      [63:0]         voltage_result,
	output logic      [63:0]         discovery_result,
	output logic      [63:0]         temp_result
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam int unsigned NP = pfs_pkg::PORTS;
	localparam int unsigned SW = $clog2(SETTLE_LIMIT + 1);

	typedef struct packed {
		pfs_pkg::pfs_state_t st;
		logic [3:0]          func;
		logic [SW-1:0]       settle;
		logic [4:0]          samples;
		logic                power;
		logic [7:0]          drive;
		logic                start;
		logic [1:0]          chan;
		logic                done;
		logic [2:0]          fault;
		logic [15:0]         i_res;
		logic [15:0]         v_res;
		logic [15:0]         d_res;
		logic [15:0]         t_res;
	} pfs_port_t;

	typedef struct packed {
		logic [3:0] oc_s1;
		logic [3:0] oc_s2;
		logic [3:0] lim_s1;
		logic [3:0] lim_s2;
		logic [3:0] uc_s1;
		logic [3:0] uc_s2;
		logic [3:0] rc_s1;
		logic [3:0] rc_s2;
		logic [3:0] rc_s3;
		pfs_port_t [NP-1:0] p;
	} pfs_seq_state_t;

	pfs_seq_state_t cur;
	pfs_seq_state_t next_cur;
	logic [3:0]     oc_expired;
	logic [3:0]     disc_expired;
	logic [3:0]     oc_cond;
	logic [3:0]     uc_armed;

	if (NP != 4 || SETTLE_LIMIT < 1)
	begin : g_bad_config
		$error("sequencer serves four ports and a nonzero settle");
	end

	// ----------------------------------------------------------------
	// per-port fault timers
	// ----------------------------------------------------------------
	// trip condition only counts while the port is powered
	assign oc_cond = cur.oc_s2 | cur.lim_s2; // R1

	genvar g;
	generate
		for (g = 0; g < NP; g++)
		begin : g_port
			assign uc_armed[g] = cur.p[g].power
				&& cur.p[g].func == pfs_pkg::FN_CONT_SAMPLE; // R4
			pfs_fault_timer #(.LIMIT(OC_LIMIT)) u_oc (
				.clock   (clock),
				.rst_n   (rst_n),
				.arm     (cur.p[g].power),
				.cond    (oc_cond[g]), // R3
				.expired (oc_expired[g])
			); // R23
			pfs_fault_timer #(.LIMIT(DISC_LIMIT)) u_disc (
				.clock   (clock),
				.rst_n   (rst_n),
				.arm     (uc_armed[g]),
				.cond    (cur.uc_s2[g]), // R6
				.expired (disc_expired[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [15:0] word;
		word = 16'h0000;
		next_cur = cur;
		next_cur.oc_s1  = overcurrent_comparator;
		next_cur.oc_s2  = cur.oc_s1;
		next_cur.lim_s1 = current_limit_comparator;
		next_cur.lim_s2 = cur.lim_s1;
		next_cur.uc_s1  = undercurrent;
		next_cur.uc_s2  = cur.uc_s1;
		next_cur.rc_s1  = ramp_complete;
		next_cur.rc_s2  = cur.rc_s1;
		next_cur.rc_s3  = cur.rc_s2;
		for (int i = 0; i < NP; i++)
		begin
			next_cur.p[i].start = 1'b0;
			word = {1'b1, conv_data}; // R20
			case (cur.p[i].st)
				pfs_pkg::ST_SETTLE:
				begin
					if (cur.p[i].settle == SW'(SETTLE_LIMIT - 1))
					begin
						next_cur.p[i].st = pfs_pkg::ST_CONVERT;
						next_cur.p[i].start = 1'b1;
					end
					else
						next_cur.p[i].settle = cur.p[i].settle + SW'(1);
				end
				pfs_pkg::ST_CONVERT:
				begin
					// finish only on converter's done, not a count
					if (conv_done[i]) // R22
					begin
						next_cur.p[i].st = pfs_pkg::ST_DONE;
						case (cur.p[i].func)
							pfs_pkg::FN_DISCOVER1,
							pfs_pkg::FN_DISCOVER2:
								next_cur.p[i].d_res = word; // R10 R11
							pfs_pkg::FN_CLASSIFY,
							pfs_pkg::FN_CURRENT_SAMPLE_FUNCTION:
								next_cur.p[i].i_res = word; // R14 R19
							pfs_pkg::FN_TEMPERATURE_SAMPLE_FUNCTION:
								next_cur.p[i].t_res = word; // R19
							pfs_pkg::FN_CONT_SAMPLE:
							begin
								if (cur.p[i].chan == pfs_pkg::CH_VOLTAGE)
									next_cur.p[i].v_res = word;
								else
									next_cur.p[i].i_res = word;
								// loop until another call or a fault shutdown
								next_cur.p[i].st = pfs_pkg::ST_CONVERT;
								next_cur.p[i].start = 1'b1;
								if (cur.p[i].samples ==
									5'(pfs_pkg::SAMPLES_PER_LOOP))
								begin
									next_cur.p[i].samples = 5'h0;
									next_cur.p[i].chan = pfs_pkg::CH_CURRENT;
								end
								else
								begin
									next_cur.p[i].samples =
										cur.p[i].samples + 5'h1;
									if (cur.p[i].samples ==
										5'(pfs_pkg::SAMPLES_PER_LOOP - 1))
										next_cur.p[i].chan =
											pfs_pkg::CH_VOLTAGE; // R16
								end
								next_cur.p[i].done = 1'b1;
							end
							default:
								next_cur.p[i].v_res = word; // R12 R13 R18
						endcase
						if (cur.p[i].func != pfs_pkg::FN_CONT_SAMPLE)
							next_cur.p[i].done = 1'b1;
					end
				end
				pfs_pkg::ST_RAMP:
				begin
					// edge only, so a stale level from the last ramp cannot end it
					if (cur.rc_s2[i] && !cur.rc_s3[i]) // R15 R17
					begin
						next_cur.p[i].st = pfs_pkg::ST_DONE;
						next_cur.p[i].done = 1'b1;
						next_cur.p[i].drive[5] = 1'b0;
						next_cur.p[i].drive[6] = 1'b0;
						if (cur.p[i].func == pfs_pkg::FN_RAMP_DOWN)
							next_cur.p[i].power = 1'b0; // R17
					end
				end
				pfs_pkg::ST_IDLE,
				pfs_pkg::ST_DONE:
					next_cur.p[i].st = cur.p[i].st; // R8
				default:
					next_cur.p[i].st = pfs_pkg::ST_IDLE;
			endcase

			// host call replaces held state of this port only
			if (call_valid && host_managed_mode
				&& call_port == 2'(i)) // R7 R21 R23
			begin
				next_cur.p[i].func = call_func;
				next_cur.p[i].done = 1'b0;
				next_cur.p[i].settle = '0;
				next_cur.p[i].samples = 5'h0;
				next_cur.p[i].drive = 8'h00;
				next_cur.p[i].chan = pfs_pkg::CH_VOLTAGE;
				next_cur.p[i].start = 1'b0;
				next_cur.p[i].st = pfs_pkg::ST_CONVERT;
				case (call_func)
					pfs_pkg::FN_DISABLE:
					begin
						next_cur.p[i] = '0; // R9
						next_cur.p[i].done = 1'b1;
						next_cur.p[i].st = pfs_pkg::ST_DONE;
					end
					pfs_pkg::FN_DISCOVER1:
					begin
						next_cur.p[i].drive[0] = 1'b1; // R10
						next_cur.p[i].chan = pfs_pkg::CH_CURRENT;
						next_cur.p[i].st = pfs_pkg::ST_SETTLE;
					end
					pfs_pkg::FN_DISCOVER2:
					begin
						next_cur.p[i].drive[1] = 1'b1; // R11
						next_cur.p[i].chan = pfs_pkg::CH_CURRENT;
						next_cur.p[i].st = pfs_pkg::ST_SETTLE;
					end
					pfs_pkg::FN_LEGACY:
					begin
						next_cur.p[i].drive[3] = 1'b1; // R13
						next_cur.p[i].start = 1'b1;
					end
					pfs_pkg::FN_CLASSIFY:
					begin
						next_cur.p[i].drive[2] = 1'b1; // R14
						next_cur.p[i].chan = pfs_pkg::CH_CURRENT;
						next_cur.p[i].start = 1'b1;
					end
					pfs_pkg::FN_RAMP_UP:
					begin
						next_cur.p[i].drive[5] = 1'b1; // R15
						next_cur.p[i].power = 1'b1;
						next_cur.p[i].fault = pfs_pkg::FAULT_NONE;
						next_cur.p[i].st = pfs_pkg::ST_RAMP;
					end
					pfs_pkg::FN_CONT_SAMPLE:
					begin
						next_cur.p[i].chan = pfs_pkg::CH_CURRENT; // R16
						next_cur.p[i].start = 1'b1;
					end
					pfs_pkg::FN_RAMP_DOWN:
					begin
						next_cur.p[i].drive[6] = 1'b1; // R17
						next_cur.p[i].st = pfs_pkg::ST_RAMP;
					end
					pfs_pkg::FN_LOW_AC:
					begin
						next_cur.p[i].drive[7] = 1'b1; // R18
						next_cur.p[i].start = 1'b1;
					end
					pfs_pkg::FN_HIGH_AC:
					begin
						next_cur.p[i].drive[4] = 1'b1; // R18
						next_cur.p[i].start = 1'b1;
					end
					pfs_pkg::FN_CURRENT_SAMPLE_FUNCTION:
					begin
						next_cur.p[i].chan = pfs_pkg::CH_CURRENT; // R19
						next_cur.p[i].start = 1'b1;
					end
					pfs_pkg::FN_TEMPERATURE_SAMPLE_FUNCTION:
					begin
						next_cur.p[i].chan = pfs_pkg::CH_TEMP; // R19
						next_cur.p[i].start = 1'b1;
					end
					pfs_pkg::FN_VSAMPLE:
						next_cur.p[i].start = 1'b1; // R12
					default:
					begin
						next_cur.p[i].done = 1'b1;
						next_cur.p[i].st = pfs_pkg::ST_DONE;
					end
				endcase
			end

			// fault shutdown wins over a same-cycle call
			if (oc_expired[i])
			begin
				next_cur.p[i].power = 1'b0; // R2
				next_cur.p[i].drive = 8'h00;
				next_cur.p[i].st = pfs_pkg::ST_IDLE;
				next_cur.p[i].fault = pfs_pkg::FAULT_OVERCURR; // R2
			end
			else if (disc_expired[i])
			begin
				next_cur.p[i].power = 1'b0; // R5
				next_cur.p[i].drive = 8'h00;
				next_cur.p[i].st = pfs_pkg::ST_IDLE;
				next_cur.p[i].fault = pfs_pkg::FAULT_DISCONNECT; // R5
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < NP; i++)
		begin
			port_power[i]    = cur.p[i].power;
			probe_low[i]     = cur.p[i].drive[0];
			probe_high[i]    = cur.p[i].drive[1];
			class_drive[i]   = cur.p[i].drive[2];
			legacy_source[i] = cur.p[i].drive[3];
			high_fet_on[i]   = cur.p[i].drive[4];
			ramp_up[i]       = cur.p[i].drive[5];
			ramp_down[i]     = cur.p[i].drive[6];
			low_fet_on[i]    = cur.p[i].drive[7];
			conv_start[i]    = cur.p[i].start;
			func_done[i]     = cur.p[i].done;
			conv_chan[2*i +: 2]         = cur.p[i].chan;
			fault_code[3*i +: 3]        = cur.p[i].fault;
			current_result[16*i +: 16]  = cur.p[i].i_res;
			voltage_result[16*i +: 16]  = cur.p[i].v_res;
			discovery_result[16*i +: 16] = cur.p[i].d_res;
			temp_result[16*i +: 16]     = cur.p[i].t_res;
		end
	end

endmodule // pfs_port_sequencer

// ===== sim/pfs_seq_sva.sv
`timescale 1ns/1ps

module pfs_seq_sva #(
	parameter int unsigned OC_LIMIT = 20
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [3:0]  overcurrent_comparator,
	input wire logic [3:0]  current_limit_comparator,
	input wire logic [3:0]  undercurrent,
	input wire logic [3:0]  ramp_complete,
	input wire logic        host_managed_mode,
	input wire logic        call_valid,
	input wire logic [1:0]  call_port,
	input wire logic [3:0]  call_func,
	input wire logic [3:0]  conv_done,
	input wire logic [14:0] conv_data,
	input wire logic [3:0]  port_power,
	input wire logic [3:0]  probe_low,
	input wire logic [3:0]  probe_high,
	input wire logic [3:0]  class_drive,
	input wire logic [3:0]  legacy_source,
	input wire logic [3:0]  ramp_up,
	input wire logic [3:0]  ramp_down,
	input wire logic [3:0]  low_fet_on,
	input wire logic [3:0]  high_fet_on,
	input wire logic [3:0]  conv_start,
	input wire logic [7:0]  conv_chan,
	input wire logic [3:0]  func_done,
	input wire logic [11:0] fault_code,
	input wire logic [63:0] current_result,
	input wire logic [63:0] voltage_result,
	input wire logic [63:0] discovery_result,
	input wire logic [63:0] temp_result
);
	// ----------------------------------------------------------------
	// trip run length on port 2, raw side of the synchronisers
	// ----------------------------------------------------------------
	logic [7:0] oc_run;
	always_ff @(posedge clock)
	begin
		if (!rst_n || !(overcurrent_comparator[2] | current_limit_comparator[2]))
			oc_run <= 8'h00;
		else if (oc_run != 8'hff)
			oc_run <= oc_run + 8'h01;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	start_pulse_a: assert property (conv_start[0] |=> !conv_start[0])
		else $error("conversion start wider than one cycle");
	vsample_start_a: assert property (call_valid && host_managed_mode
		&& call_port == 2'h0 && call_func == 4'h3 && !port_power[0]
		|=> conv_start[0] && conv_chan[1:0] == 2'h1)
		else $error("voltage sample did not start a voltage conversion");
	mode_ignore_a: assert property (!host_managed_mode && !port_power[0]
		|=> $stable(probe_low[0]) && $stable(probe_high[0]))
		else $error("drive changed with host mode off");
	disable_off_a: assert property (call_valid && host_managed_mode
		&& call_port == 2'h0 && call_func == 4'h0
		|=> !port_power[0] && func_done[0] && voltage_result[15:0] == 16'h0000)
		else $error("disable did not clear the port");
	done_hold_a: assert property (func_done[0] && !call_valid
		&& !port_power[0] |=> func_done[0])
		else $error("done dropped without a new call");
	oc_off_a: assert property (fault_code[8:6] == 3'h2 |-> !port_power[2])
		else $error("overcurrent code with port still on");
	oc_time_a: assert property ($rose(fault_code[8:6] == 3'h2)
		|-> $past(oc_run, 3) >= OC_LIMIT - 4)
		else $error("overcurrent fault before the timeout");
	disc_fault_a: assert property ($rose(fault_code[11:9] == 3'h3)
		|-> $past(port_power[3]) && !port_power[3])
		else $error("disconnect fault on an unpowered port");
	result_flag_a: assert property ($changed(voltage_result[15:0])
		&& voltage_result[15:0] != 16'h0000 |-> voltage_result[15])
		else $error("result written without complete flag");
endmodule // pfs_seq_sva

bind pfs_port_sequencer pfs_seq_sva #(.OC_LIMIT(OC_LIMIT)) pfs_seq_sva_i (.*);

// ===== sim/pfs_analog_model.sv
`timescale 1ns/1ps

module pfs_analog_model (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic [3:0]  conv_start,
	input  wire logic [7:0]  conv_chan,
	input  wire logic [3:0]  ramp_up,
	input  wire logic [3:0]  ramp_down,
	output logic      [3:0]  conv_done = 4'h0,
	output logic      [14:0] conv_data = 15'h0000,
	output logic      [3:0]  ramp_complete = 4'h0
);
	// ----------------------------------------------------------------
	// converter and ramp stand-in, two counters per port
	// ----------------------------------------------------------------
	int         wait_n [4];
	int         ramp_n [4];
	logic [1:0] chan   [4];
	always @(posedge clock)
	begin
		conv_done <= 4'h0;
		// data is only valid with done; scramble it otherwise
		conv_data <= ~conv_data;
		for (int p = 0; p < 4; p++)
		begin
			if (!rst_n)
				wait_n[p] = 0;
			else if (conv_start[p])
			begin
				wait_n[p] = slow ? 40 : 3;
				chan[p] = conv_chan[2*p +: 2];
			end
			else if (wait_n[p] > 0)
			begin
				wait_n[p]--;
				if (wait_n[p] == 0)
				begin
					conv_done[p] <= 1'b1;
					conv_data <= {9'h0a5, chan[p], 2'(p), 2'h1};
				end
			end
			ramp_n[p] = (rst_n && (ramp_up[p] | ramp_down[p])) ? ramp_n[p] + 1 : 0;
			ramp_complete[p] <= ramp_n[p] >= 4;
		end
	end
endmodule // pfs_analog_model

// ===== sim/pfs_port_sequencer_tb_top.sv
`timescale 1ns/1ps

module pfs_port_sequencer_tb_top;
	logic        clock, rst_n, host_managed_mode, call_valid, slow;
	logic [1:0]  call_port;
	logic [3:0]  call_func, overcurrent_comparator, current_limit_comparator;
	logic [3:0]  undercurrent, ramp_complete, conv_done, conv_start;
	logic [3:0]  port_power, probe_low, probe_high, class_drive, legacy_source;
	logic [3:0]  ramp_up, ramp_down, low_fet_on, high_fet_on, func_done;
	logic [7:0]  conv_chan;
	logic [11:0] fault_code;
	logic [14:0] conv_data;
	logic [63:0] current_result, voltage_result, discovery_result, temp_result;
	int          fails, total_checks, cycles;

	pfs_port_sequencer #(.OC_LIMIT(20), .DISC_LIMIT(40), .SETTLE_LIMIT(5))
		pfs_port_sequencer_i (.*);
	pfs_analog_model pfs_analog_model_i (.*);

	// ----------------------------------------------------------------
	// clock, hang guard, helpers
	// ----------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			fails++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic call(input logic [1:0] p, input logic [3:0] f);
		@(posedge clock);
		call_port <= p;
		call_func <= f;
		call_valid <= 1'b1;
		@(posedge clock);
		call_valid <= 1'b0;
	endtask

	// every call but the continuous-sample, mode-off and reserved-code ones waits here, so no call lands mid-conversion
	task automatic wait_done(input int p);
		int n;
		n = 0;
		#1;
		while (func_done[p] !== 1'b1 && n < 400)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		check("func_done", 16'h0001, {15'h0000, func_done[p]});
	endtask

	function automatic logic [15:0] exp_res(input int p, input logic [1:0] c);
		return {1'b1, 9'h0a5, c, 2'(p), 2'h1};
	endfunction

	// {result select, channel, drive pattern} per function code
	function automatic logic [9:0] fn_row(input logic [3:0] f);
		case (f)
			4'h1: return 10'h201;
			4'h2: return 10'h202;
			4'h3: return 10'h140;
			4'h4: return 10'h148;
			4'h5: return 10'h004;
			4'h9: return 10'h150;
			4'ha: return 10'h160;
			4'hb: return 10'h000;
			default: return 10'h380;
		endcase
	endfunction

	function automatic logic [15:0] res(input logic [1:0] s, input int p);
		case (s)
			2'h0: return current_result[16*p +: 16];
			2'h1: return voltage_result[16*p +: 16];
			2'h2: return discovery_result[16*p +: 16];
			default: return temp_result[16*p +: 16];
		endcase
	endfunction

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_functions();
		logic [9:0] row;
		logic [5:0] drv;
		for (int i = 1; i < 13; i++)
		begin
			if (i >= 6 && i <= 8)
				continue;
			row = fn_row(4'(i));
			call(2'h1, 4'(i));
			wait_done(1);
			check("result", exp_res(1, row[7:6]), res(row[9:8], 1));
			drv = {high_fet_on[1], low_fet_on[1], legacy_source[1],
				class_drive[1], probe_high[1], probe_low[1]};
			check("drive", {10'h000, row[5:0]}, {10'h000, drv});
		end
	endtask

	task automatic t_slow_then_disable();
		slow <= 1'b1;
		call(2'h0, 4'h3);
		repeat (10) @(posedge clock);
		#1;
		check("early_done", 16'h0000, {15'h0000, func_done[0]});
		wait_done(0);
		check("vresult", exp_res(0, 2'h1), voltage_result[15:0]);
		@(posedge clock);
		slow <= 1'b0;
		call(2'h0, 4'h0);
		wait_done(0);
		check("cleared", 16'h0000, voltage_result[15:0]);
		check("other_port", exp_res(1, 2'h1), voltage_result[31:16]);
	endtask

	task automatic t_mode_off();
		@(posedge clock);
		host_managed_mode <= 1'b0;
		call(2'h0, 4'h3);
		repeat (10) @(posedge clock);
		#1;
		check("ignored", 16'h0000, {15'h0000, conv_start[0]} | voltage_result[15:0]);
		@(posedge clock);
		host_managed_mode <= 1'b1;
		call(2'h0, 4'hd);
		#1;
		check("reserved", 16'h0001, {14'h0000, conv_start[0], func_done[0]});
	endtask

	task automatic t_overcurrent();
		call(2'h2, 4'h6);
		#1;
		check("ramping", 16'h0003, {14'h0000, ramp_up[2], port_power[2]});
		wait_done(2);
		check("powered", 16'h0001, {14'h0000, ramp_up[2], port_power[2]});
		@(posedge clock);
		overcurrent_comparator[2] <= 1'b1;
		repeat (10) @(posedge clock);
		overcurrent_comparator[2] <= 1'b0;
		repeat (10) @(posedge clock);
		#1;
		check("oc_short", 16'h0001, {12'h000, fault_code[8:6], port_power[2]});
		@(posedge clock);
		current_limit_comparator[2] <= 1'b1;
		repeat (40) @(posedge clock);
		#1;
		check("oc_fault", 16'h0004, {12'h000, fault_code[8:6], port_power[2]});
		@(posedge clock);
		current_limit_comparator[2] <= 1'b0;
	endtask

	task automatic t_cont_sample();
		int n;
		call(2'h3, 4'h6);
		wait_done(3);
		call(2'h3, 4'h7);
		#1;
		for (int i = 0; i < 32; i++)
		begin
			n = 0;
			// step off the pulse just checked before looking for the next
			if (i > 0)
			begin
				@(posedge clock);
				#1;
			end
			while (conv_start[3] !== 1'b1 && n < 100)
			begin
				@(posedge clock);
				#1;
				n++;
			end
			check("chan", (i < 31) ? 16'h0000 : 16'h0001, {14'h0000, conv_chan[7:6]});
		end
		check("cur", exp_res(3, 2'h0), current_result[63:48]);
		@(posedge clock);
		undercurrent[3] <= 1'b1;
		repeat (20) @(posedge clock);
		undercurrent[3] <= 1'b0;
		repeat (5) @(posedge clock);
		#1;
		check("uc_short", 16'h0001, {12'h000, fault_code[11:9], port_power[3]});
		check("vres", exp_res(3, 2'h1), voltage_result[63:48]);
		@(posedge clock);
		undercurrent[3] <= 1'b1;
		repeat (60) @(posedge clock);
		#1;
		check("uc_fault", 16'h0006, {12'h000, fault_code[11:9], port_power[3]});
	endtask

	task automatic t_ramp_down();
		call(2'h1, 4'h6);
		wait_done(1);
		call(2'h1, 4'h8);
		#1;
		check("rdown_on", 16'h0003, {14'h0000, ramp_down[1], port_power[1]});
		repeat (3) @(posedge clock);
		#1;
		check("rdown_wait", 16'h0003, {13'h0000, func_done[1], ramp_down[1], port_power[1]});
		wait_done(1);
		check("ramp_off", 16'h0000, {14'h0000, ramp_down[1], port_power[1]});
	endtask

	initial
	begin
		{rst_n, call_valid, slow, call_port, call_func} = '0;
		{overcurrent_comparator, current_limit_comparator, undercurrent} = '0;
		host_managed_mode = 1'b1;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_functions();
		t_slow_then_disable();
		t_mode_off();
		t_overcurrent();
		t_cont_sample();
		t_ramp_down();
		print_verdict();
	end
endmodule // pfs_port_sequencer_tb_top
